// ==== core/tbpw_map.svh ====
// constants for the timer based pwm channel: register offsets, fields, resets
// assumes an apb slave with 32-bit data, one aligned word per register
//
// Functional notes
// (R01) ten-bit duty compared against ten-bit time base
// (R02) shared timer and limit set every period
// (R03) timer postscaler never affects pwm frequency
// (R04) output goes active when timer clears
// (R05) output inactive when time base equals duty
// (R06) duty at or above limit stays active; the code keeps it active only for duty above limit_ext
// (R07) duty registers shadowed, loaded on limit match
// (R08) software writes both duty halves before match
// (R09) output muxed with port latch, direction bit
// (R10) polarity bit inverts output to active low
// (R11) after match: clear timer, set output, load
// (R12) time base extends count with prescaled bits
// (R13) channel runs only while enable bit set
`ifndef TBPW_MAP_SVH
`define TBPW_MAP_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TBPW_OFS_LIMIT 12'h000
`define TBPW_OFS_TCTRL 12'h004
`define TBPW_OFS_COUNT 12'h008
`define TBPW_OFS_DHIGH 12'h00C
`define TBPW_OFS_DLOW 12'h010
`define TBPW_OFS_CCTRL 12'h014
`define TBPW_OFS_PORT 12'h018
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TBPW_CC_EN 7
`define TBPW_CC_OUT 5
`define TBPW_CC_POL 4
`define TBPW_TC_ON 2
`define TBPW_PORT_LATCH 0
`define TBPW_PORT_DIR 1
`define TBPW_PORT_SEL 2
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TBPW_RST_LIMIT 8'hFF
`define TBPW_RST_BYTE 8'h00
`define TBPW_RST_PORT 3'h2
`endif

// ==== core/tbpw_pkg.sv ====
// types shared by the pwm channel
// assumes the map header supplies the numbers
package tbpw_pkg;
   // prescale choices held in the timer control field
   typedef enum logic [1:0] {TBPW_PS1, TBPW_PS4, TBPW_PS16, TBPW_PS64} tbpw_ps_t;
endpackage

// ==== core/tbpw_channel.sv ====
// one pwm channel with its own period timer, reached over apb
// assumes pclk is the system clock; port pin drivers sit outside
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/100ps
`include "tbpw_map.svh"

module tbpw_channel #(
   parameter int DUTY_W = 10,
   parameter int CNT_W = 8
) (
   // apb clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // waveform to other peripherals
   output logic pwm_out,
   // port pin, driven while direction selects output
   output logic pin_o,
   output logic pin_oe,
   // one pulse per period for postscaler users
   output logic period_tick
);

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   // the split into high byte and two low bits fixes these widths
   if (DUTY_W != CNT_W + 2) begin : g_bad_w
      $error("duty width must be count width plus two");
   end
   if (CNT_W != 8) begin : g_bad_c
      $error("count width must be 8 to match byte registers");
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [7:0] period_limit_r; // period length
   logic [7:0] period_timer_control_r; // prescale, on bit
   logic [7:0] period_timer_count_r; // timer count
   logic [7:0] duty_high_r; // eight msbs
   logic [7:0] duty_low_r; // bits 7:6 are the two lsbs
   logic [7:0] channel_control_r; // enable, polarity
   logic [2:0] port_r; // latch, direction, mux select
   logic [5:0] presc_r; // prescaler and sub-count
   logic [DUTY_W-1:0] duty_buf_r; // active compare value
   logic act_r; // raw active level
   logic [31:0] rd_nxt; // read mux

   wire logic wr_en = psel & penable & pwrite;
   wire logic timer_on = period_timer_control_r[`TBPW_TC_ON];
   wire logic chan_en = channel_control_r[`TBPW_CC_EN];
   wire tbpw_pkg::tbpw_ps_t ps_sel = tbpw_pkg::tbpw_ps_t'(period_timer_control_r[1:0]);

   // ----------------------------------------------------------------
   // prescaler and time base
   // ----------------------------------------------------------------
   // prescaled sub-count; its top two bits are the time base lsbs
   logic [5:0] presc_top;
   always_comb begin
      case (ps_sel)
         tbpw_pkg::TBPW_PS1: presc_top = 6'h03;
         tbpw_pkg::TBPW_PS4: presc_top = 6'h0F;
         tbpw_pkg::TBPW_PS16: presc_top = 6'h3F;
         default: presc_top = 6'h3F;
      endcase
   end
   // 1:64 runs four full passes of the 1:16 sub-count per count step; the
   // pass number in slow_r then supplies the two time base lsbs, so a
   // wider prescaler counter is not needed
   logic [1:0] slow_r; // pass number, used as lsbs only at 1:64
   wire logic slow_ok = (ps_sel != tbpw_pkg::TBPW_PS64) || (slow_r == 2'h3);
   wire logic presc_wrap = (presc_r == presc_top) && slow_ok;
   // sub bits step once per prescaled clock in every mode
   wire logic [1:0] sub_bits = (ps_sel == tbpw_pkg::TBPW_PS1) ? presc_r[1:0] :
      (ps_sel == tbpw_pkg::TBPW_PS4) ? presc_r[3:2] :
      (ps_sel == tbpw_pkg::TBPW_PS16) ? presc_r[5:4] : slow_r;
   // (R12) count extended by prescaled sub bits
   wire logic [DUTY_W-1:0] time_base = {period_timer_count_r, sub_bits};
   wire logic match = (period_timer_count_r == period_limit_r);
   wire logic restart = timer_on && presc_wrap && match;

   // a prescale change while running distorts the time base until presc_r
   // next wraps to zero; a restart does not realign the sub-count
   // prescaler runs on every clock while the timer is on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc_r <= 6'h00;
         slow_r <= 2'h0;
      end else if (!timer_on) begin
         presc_r <= 6'h00;
         slow_r <= 2'h0;
      end else if (presc_r == presc_top) begin
         presc_r <= 6'h00;
         slow_r <= slow_r + 2'h1;
      end else begin
         presc_r <= presc_r + 6'h01;
      end
   end

   // ----------------------------------------------------------------
   // period timer
   // ----------------------------------------------------------------
   // (R02) one timer and limit give the period
   // (R03) no postscaler term touches the count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         period_timer_count_r <= 8'h00;
      end else if (wr_en && paddr == `TBPW_OFS_COUNT) begin
         period_timer_count_r <= pwdata[7:0];
      end else if (timer_on && presc_wrap) begin
         // (R11) clear on increment after match
         period_timer_count_r <= match ? 8'h00 : period_timer_count_r + 8'h01;
      end
   end

   // period tick for other users of the timer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         period_tick <= 1'b0;
      end else begin
         period_tick <= restart;
      end
   end

   // ----------------------------------------------------------------
   // duty shadow and compare
   // ----------------------------------------------------------------
   wire logic [DUTY_W-1:0] duty_new = {duty_high_r, duty_low_r[7:6]};
   // (R07) shadow copied only on match restart
   // (R08) both halves taken together here
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         duty_buf_r <= '0;
      end else if (restart) begin
         duty_buf_r <= duty_new;
      end
   end

   // raw output level, before polarity
   // (R06) duty above limit_ext never compares equal within a period
   wire logic [DUTY_W-1:0] limit_ext = {period_limit_r, 2'h3};
   wire logic never_clr = (duty_buf_r > limit_ext);
   // the compare hit drops the level in the same cycle that the time base
   // reaches the duty value; act_r only remembers it, so the high time is
   // exactly the duty value in time base steps and not one clock longer
   wire logic hit = timer_on && (time_base == duty_buf_r) && !never_clr;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_r <= 1'b0;
      end else if (!chan_en) begin
         // (R13) disabled channel held inactive
         act_r <= 1'b0;
      end else if (restart) begin
         // (R04) active on clear, unless duty is zero
         // (R11) zero duty stays inactive
         act_r <= (duty_new != '0);
      end else if (hit) begin
         // (R01) ten-bit compare
         // (R05) equality returns output inactive
         act_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // output stage
   // ----------------------------------------------------------------
   // (R10) polarity bit inverts
   wire logic act_lvl = act_r && !hit; // level seen by the outputs
   wire logic pol_lvl = act_lvl ^ channel_control_r[`TBPW_CC_POL];
   // (R09) pin mux between port latch and channel
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_out <= 1'b0;
         pin_o <= 1'b0;
         pin_oe <= 1'b0;
      end else begin
         pwm_out <= pol_lvl;
         pin_o <= port_r[`TBPW_PORT_SEL] ? pol_lvl : port_r[`TBPW_PORT_LATCH];
         // direction bit set means input, so driver off
         pin_oe <= !port_r[`TBPW_PORT_DIR];
      end
   end

   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         period_limit_r <= `TBPW_RST_LIMIT;
         period_timer_control_r <= `TBPW_RST_BYTE;
         duty_high_r <= `TBPW_RST_BYTE;
         duty_low_r <= `TBPW_RST_BYTE;
         channel_control_r <= `TBPW_RST_BYTE;
         port_r <= `TBPW_RST_PORT;
      end else if (wr_en) begin
         case (paddr)
            `TBPW_OFS_LIMIT: period_limit_r <= pwdata[7:0];
            `TBPW_OFS_TCTRL: period_timer_control_r <= {5'h00, pwdata[2:0]};
            `TBPW_OFS_DHIGH: duty_high_r <= pwdata[7:0];
            `TBPW_OFS_DLOW: duty_low_r <= {pwdata[7:6], 6'h00};
            `TBPW_OFS_CCTRL: channel_control_r <= {pwdata[7], 2'h0, pwdata[4], 4'h0};
            `TBPW_OFS_PORT: port_r <= pwdata[2:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // read mux and apb answer
   // ----------------------------------------------------------------
   always_comb begin
      rd_nxt = 32'h0000_0000;
      case (paddr)
         `TBPW_OFS_LIMIT: rd_nxt[7:0] = period_limit_r;
         `TBPW_OFS_TCTRL: rd_nxt[7:0] = period_timer_control_r;
         `TBPW_OFS_COUNT: rd_nxt[7:0] = period_timer_count_r;
         `TBPW_OFS_DHIGH: rd_nxt[7:0] = duty_high_r;
         `TBPW_OFS_DLOW: rd_nxt[7:0] = duty_low_r;
         `TBPW_OFS_CCTRL: begin
            rd_nxt[7:0] = channel_control_r;
            rd_nxt[`TBPW_CC_OUT] = pol_lvl;
         end
         `TBPW_OFS_PORT: rd_nxt[2:0] = port_r;
         default: rd_nxt = 32'h0000_0000;
      endcase
   end

   // zero wait states: the answer is ready in the first access cycle
   wire logic known = (paddr[11:5] == 7'h00) && (paddr[4:2] != 3'h7) && (paddr[1:0] == 2'h0);
   wire logic setup_ph = psel & !penable; // first cycle of a transfer
   // read data and error are captured in the setup cycle so that every bus
   // output leaves a flip-flop; the trade-off is that a read returns the
   // value one clock before the access edge, which only the running count
   // and the live output bit can notice
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setup_ph) begin
         // held through the access cycle that follows
         prdata <= rd_nxt;
         pslverr <= !known;
      end else begin
         // answer stands for the access cycle only
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
   end
   // ready is a flip-flop that leaves reset high and stays high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b1;
      end else begin
         pready <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_dis_inactive: assert property (@(posedge pclk) disable iff (!presetn) // (R13)
      !chan_en |=> !act_r) else $error("disabled channel active");
   a_restart_load: assert property (@(posedge pclk) disable iff (!presetn) // (R07)
      restart |=> duty_buf_r == $past(duty_new)) else $error("buffer not loaded");
   a_hold_buf: assert property (@(posedge pclk) disable iff (!presetn) // (R07)
      !restart |=> $stable(duty_buf_r)) else $error("buffer moved off match");
   a_set_active: assert property (@(posedge pclk) disable iff (!presetn) // (R04)
      restart && chan_en && duty_new != '0 |=> act_r) else $error("not active at clear");
   a_zero_duty: assert property (@(posedge pclk) disable iff (!presetn) // (R11)
      restart && duty_new == '0 |=> !act_r) else $error("zero duty went active");
   a_clear_eq: assert property (@(posedge pclk) disable iff (!presetn) // (R05)
      hit && !restart |=> !act_r)
      else $error("not cleared at compare");
   a_full_duty: assert property (@(posedge pclk) disable iff (!presetn) // (R06)
      act_r && chan_en && never_clr && !restart |=> act_r) else $error("full duty dropped");
   a_timer_clr: assert property (@(posedge pclk) disable iff (!presetn) // (R11)
      restart && !(wr_en && paddr == `TBPW_OFS_COUNT) |=> period_timer_count_r == 8'h00)
      else $error("timer not cleared");
   a_polarity: assert property (@(posedge pclk) disable iff (!presetn) // (R10)
      ##1 pwm_out == ($past(act_lvl) ^ $past(channel_control_r[`TBPW_CC_POL])))
      else $error("polarity wrong");
   // one clock after its cause: tick, count step and pin stage
   a_tick_pulse: assert property (@(posedge pclk) disable iff (!presetn) // (R03)
      ##1 period_tick == $past(restart)) else $error("period tick misplaced");
   a_count_step: assert property (@(posedge pclk) disable iff (!presetn) // (R02)
      timer_on && presc_wrap && !match && !(wr_en && paddr == `TBPW_OFS_COUNT)
      |=> period_timer_count_r == $past(period_timer_count_r) + 8'h01)
      else $error("timer did not step");
   a_pin_mux: assert property (@(posedge pclk) disable iff (!presetn) // (R09)
      ##1 pin_o == ($past(port_r[`TBPW_PORT_SEL]) ? $past(pol_lvl) :
      $past(port_r[`TBPW_PORT_LATCH]))) else $error("pin source wrong");
   a_pin_drive: assert property (@(posedge pclk) disable iff (!presetn) // (R09)
      ##1 pin_oe == !$past(port_r[`TBPW_PORT_DIR])) else $error("pin driver wrong");

endmodule

// ==== bench/tbpw_pin_model.sv ====
// far-side model of the port pin fed by the channel
// assumes pin_oe high while the channel drives; no pull on the line
`timescale 1ns/100ps
module tbpw_pin_model (
   // clock
   input wire logic pclk,
   // pin driver from the channel
   input wire logic pin_o,
   input wire logic pin_oe,
   // level seen on the line
   output logic pin_lvl
);
   logic last_r = 1'b0; // last level the channel drove
   // a released line shows the inverse of the last driven level, so a
   // stale value can never pass for a driven one
   always @(posedge pclk) begin
      if (pin_oe) begin
         last_r <= pin_o;
      end
   end
   assign pin_lvl = pin_oe ? pin_o : ~last_r;
endmodule

// ==== bench/timer_based_pwm_channel_tb.sv ====
// self-checking bench: apb setup, waveform timing, pin mux
// assumes zero-wait apb and registered outputs
`timescale 1ns/100ps
`include "tbpw_map.svh"
module timer_based_pwm_channel_tb;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic pready, pslverr, pwm_out, pin_o, pin_oe, period_tick, pin_lvl, err;
   logic watch = 1'b0; // monitor the pin instead of pwm_out
   int tk, ticks = 0; // period ticks seen
   logic inv = 1'b0; // active-low view
   int err_total = 0, cmp_count = 0, cyc = 0, t0, t1, t2, lim, d, dn, seed, hi, per, bad;
   logic [11:0] ofs [6] = '{`TBPW_OFS_LIMIT, `TBPW_OFS_TCTRL, `TBPW_OFS_DHIGH,
      `TBPW_OFS_DLOW, `TBPW_OFS_CCTRL, `TBPW_OFS_PORT};
   logic [31:0] rst [6] = '{32'h0000_00FF, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0000_0002};
   wire mon = (watch ? pin_lvl : pwm_out) ^ inv;
   initial forever #5 pclk = ~pclk;
   tbpw_channel tbpw_channel_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pwm_out(pwm_out), .pin_o(pin_o),
      .pin_oe(pin_oe), .period_tick(period_tick));
   tbpw_pin_model tbpw_pin_model_inst (.pclk(pclk), .pin_o(pin_o), .pin_oe(pin_oe),
      .pin_lvl(pin_lvl));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("FAIL %0t %s: saw %0h expected %0h", $time, msg, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // one apb transfer held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic set_duty(input int v);
      apb(1'b1, `TBPW_OFS_DHIGH, {24'h00_0000, v[9:2]});
      apb(1'b1, `TBPW_OFS_DLOW, {24'h00_0000, v[1:0], 6'h00});
   endtask
   // outputs are sampled on the falling edge, well clear of updates
   task automatic wait_lvl(input logic v, output int t);
      @(negedge pclk);
      while (mon !== v) @(negedge pclk);
      t = cyc;
   endtask
   task automatic hold(input logic v, input int n, output int b);
      b = 0;
      repeat (n) begin
         @(negedge pclk);
         if (mon !== v) b++;
      end
   endtask
   // skip a period so new settings are loaded, then time one period
   task automatic meas(output int h, output int p);
      wait_lvl(1'b1, t0);
      wait_lvl(1'b0, t0);
      wait_lvl(1'b1, t0);
      wait_lvl(1'b0, t1);
      wait_lvl(1'b1, t2);
      h = t1 - t0;
      p = t2 - t0;
   endtask
   // clocks per time-base step for a prescale code
   function automatic int scale(input int code);
      return 1 << (2 * code);
   endfunction
   // period ticks, counted where they are settled
   always @(negedge pclk) begin
      if (period_tick === 1'b1) ticks <= ticks + 1;
   end
   // hang guard
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_total++;
         complete_run();
      end
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      seed = $urandom(34699);
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      check(pin_oe, 1'b0, "pin driven after reset");
      foreach (ofs[i]) begin
         apb(1'b0, ofs[i], 32'h0);
         check(rd, rst[i], "reset value");
      end
      apb(1'b0, 12'h01C, 32'h0);
      check(err, 1'b1, "unmapped error");
      check(rd, 32'h0, "unmapped data");
      // the count is writable while the timer is stopped
      apb(1'b1, `TBPW_OFS_COUNT, 32'h0000_002A);
      apb(1'b0, `TBPW_OFS_COUNT, 32'h0);
      check(rd, 32'h0000_002A, "count write");
      apb(1'b1, `TBPW_OFS_COUNT, 32'h0);
      apb(1'b1, `TBPW_OFS_LIMIT, 32'h0000_0003);
      set_duty(5);
      apb(1'b1, `TBPW_OFS_CCTRL, 32'h0000_0080);
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, `TBPW_OFS_TCTRL, {29'h0000_0000, 1'b1, c[1:0]});
         meas(hi, per);
         check(hi, 5 * scale(c), "prescaled width");
         check(per, 16 * scale(c), "prescaled period");
      end
      // back to 1:1 so that one time base step is one clock
      apb(1'b1, `TBPW_OFS_TCTRL, 32'h0000_0004);
      lim = 8 + $urandom_range(32);
      apb(1'b1, `TBPW_OFS_LIMIT, lim);
      d = 16;
      set_duty(d);
      meas(hi, per);
      t0 = t2;
      tk = ticks;
      // new duty written mid-pulse must wait for the restart
      for (int i = 0; i < 8; i++) begin
         dn = (i == 3) ? 4 * lim + 3 : (i == 5) ? 4 * lim : 16 + $urandom_range(4 * lim - 13);
         set_duty(dn);
         wait_lvl(1'b0, t1);
         wait_lvl(1'b1, t2);
         check(t1 - t0, d, "shadowed width");
         check(t2 - t0, 4 * (lim + 1), "shared period");
         t0 = t2;
         d = dn;
      end
      check(ticks - tk, 8, "period ticks");
      apb(1'b1, `TBPW_OFS_CCTRL, 32'h0000_0090);
      inv = 1'b1;
      meas(hi, per);
      check(hi, d, "inverted width");
      apb(1'b1, `TBPW_OFS_PORT, 32'h0000_0004);
      watch = 1'b1;
      meas(hi, per);
      check(hi, d, "pin width");
      check(pin_oe, 1'b1, "pin enable");
      apb(1'b1, `TBPW_OFS_PORT, 32'h0000_0001);
      inv = 1'b0;
      repeat (4) @(posedge pclk);
      hold(1'b1, 50, bad);
      check(bad, 0, "latch on pin");
      apb(1'b1, `TBPW_OFS_PORT, 32'h0000_0003);
      repeat (4) @(posedge pclk);
      check(pin_oe, 1'b0, "pin released");
      watch = 1'b0;
      apb(1'b1, `TBPW_OFS_CCTRL, 32'h0000_0080);
      set_duty(1023);
      repeat (400) @(posedge pclk);
      hold(1'b1, 400, bad);
      check(bad, 0, "full duty");
      set_duty(0);
      repeat (400) @(posedge pclk);
      hold(1'b0, 400, bad);
      check(bad, 0, "zero duty");
      set_duty(d);
      apb(1'b1, `TBPW_OFS_CCTRL, 32'h0000_0000);
      repeat (10) @(posedge pclk);
      hold(1'b0, 400, bad);
      check(bad, 0, "disabled channel");
      complete_run();
   end
endmodule
